// >>> inc/wdt_pkg.sv
// Shared constants, types and helpers for the watchdog timer block
package wdt_pkg;

	// Clocking: clk_sys stands in for the oscillator
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MC_DIV = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

	// Widths of prescaler and main counter
	localparam int unsigned PRE_W = 13;
	localparam int unsigned CNT_W = 8;

	// Shortest tap period is 64 machine cycles, i.e. 6 low bits
	localparam int unsigned TAP_BASE = 6;

	// Length of the system reset pulse, rounded up to whole cycles
	localparam int unsigned RST_PULSE_NS = 128;
	localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] RST_PULSE_LAST = 5'(RST_PULSE_CYC - 1);

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_RELOAD = 5'h04;
	localparam logic [4:0] OFS_FEED = 5'h08;
	localparam logic [4:0] OFS_COUNT = 5'h0C;
	localparam logic [4:0] OFS_PRESC = 5'h10;

	// Control register field positions
	localparam int unsigned CTRL_SEL_LSB = 5;
	localparam int unsigned CTRL_RUN_BIT = 2;
	localparam int unsigned CTRL_FLAG_BIT = 1;
	localparam int unsigned CTRL_MODE_BIT = 0;

	// Reset values
	localparam logic [2:0] RST_SEL = 3'h0;
	localparam logic [7:0] RST_RELOAD = 8'hFF;
	localparam logic RST_RUN = 1'b0;
	localparam logic RST_MODE = 1'b0;

	// Avalon-MM request and response bundles
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} wdt_avs_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} wdt_avs_rsp_type;

	// Mask of prescaler low bits that must be all ones for a tap
	function automatic logic [PRE_W-1:0] wdt_tap_mask(input logic [2:0] sel);
		logic [31:0] ones;
		ones = (32'h1 << (TAP_BASE + 32'(sel))) - 32'h1;
		wdt_tap_mask = ones[PRE_W-1:0];
	endfunction

endpackage

// >>> hw/wdt_prescaler.sv
// Thirteen-bit machine-cycle prescaler with selectable tap pulse
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler
	import wdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mc_en,
	input wire logic clear,
	input wire logic [2:0] sel,
	output logic [PRE_W-1:0] count_q,
	output logic tap_q
);

	// Tap fires when the selected low bits roll over
	wire logic [PRE_W-1:0] mask_w;
	wire logic tap_w;
	assign mask_w = wdt_tap_mask(sel);
	assign tap_w = mc_en && !clear && ((count_q & mask_w) == mask_w);

	// Clear beats increment so a feed restarts the interval cleanly
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			count_q <= '0;
			tap_q <= 1'b0;
		end
		else
		begin
			if (clear)
				count_q <= '0;
			else if (mc_en)
				count_q <= count_q + 13'h0001;
			tap_q <= tap_w;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_prescale_step: assert property (mc_en && !clear |=> count_q == $past(count_q) + 13'h0001)
		else $error("prescaler did not advance on machine cycle");
	a_prescale_clear: assert property (clear |=> count_q == '0 && !tap_q)
		else $error("prescaler not cleared by feed");
	a_tap_mask: assert property (tap_q |->
		($past(count_q) & wdt_tap_mask($past(sel))) == wdt_tap_mask($past(sel)))
		else $error("tap fired with selected bits not all ones");

endmodule
`default_nettype wire

// >>> hw/wdt_watchdog.sv
// Watchdog timer top: machine-cycle divider, main counter, Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module wdt_watchdog
	import wdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire wdt_avs_req_type avs_req,
	output var wdt_avs_rsp_type avs_rsp,
	output logic sys_reset_q,
	output logic timeout_q
);

	// Machine-cycle divider state
	logic [3:0] mc_cnt_q;
	logic mc_en_q;

	// Software-visible state
	logic [2:0] sel_q;
	logic run_q;
	logic mode_q;
	logic [CNT_W-1:0] reload_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// Reset pulse stretcher
	logic [4:0] rst_cnt_q;

	// Prescaler outputs
	wire logic [PRE_W-1:0] pre_count_w;
	wire logic tap_w;

	// Bus decode; a write lands in the cycle waitrequest is low
	wire logic req_w;
	wire logic wr_acc_w;
	wire logic be0_w;
	wire logic wr_ctrl_w;
	wire logic wr_reload_w;
	wire logic feed_w;
	assign req_w = avs_req.read || avs_req.write;
	assign wr_acc_w = avs_req.write && !avs_rsp.waitrequest;
	assign be0_w = avs_req.byteenable[0];
	assign wr_ctrl_w = wr_acc_w && be0_w && (avs_req.address == OFS_CTRL);
	assign wr_reload_w = wr_acc_w && be0_w && (avs_req.address == OFS_RELOAD);
	// Any accepted write to the feed word triggers a reload, whatever its byte enables
	assign feed_w = wr_acc_w && (avs_req.address == OFS_FEED);

	// Read multiplexer; unmapped offsets read as zero
	wire logic [7:0] ctrl_rd_w;
	wire logic [31:0] rdata_w;
	assign ctrl_rd_w = {sel_q, 2'b00, run_q, timeout_q, mode_q};
	assign rdata_w =
		(avs_req.address == OFS_CTRL) ? {24'h000000, ctrl_rd_w} :
		(avs_req.address == OFS_RELOAD) ? {24'h000000, reload_q} :
		(avs_req.address == OFS_COUNT) ? {24'h000000, cnt_q} :
		(avs_req.address == OFS_PRESC) ? {19'h00000, pre_count_w} :
		32'h00000000;

	// Counter reaching zero while running is an expiry
	wire logic expire_w;
	wire logic dec_w;
	assign expire_w = run_q && (cnt_q == 8'h00);
	assign dec_w = run_q && tap_w;

	// Main counter next value; feed outranks expiry and decrement
	always_comb
	begin
		if (feed_w)
			cnt_d = reload_q;
		else if (expire_w)
			cnt_d = reload_q;
		else if (dec_w)
			cnt_d = cnt_q - 8'h01;
		else
			cnt_d = cnt_q;
	end

	// Divide clk_sys by twelve into a one-cycle machine-cycle enable
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			mc_cnt_q <= 4'h0;
			mc_en_q <= 1'b0;
		end
		else
		begin
			mc_cnt_q <= (mc_cnt_q == MC_LAST) ? 4'h0 : mc_cnt_q + 4'h1;
			mc_en_q <= (mc_cnt_q == MC_LAST);
		end
	end

	// Prescaler and tap; cleared by the feed
	wdt_prescaler u_pre (
		.clk_sys(clk_sys),
		.rst(rst),
		.mc_en(mc_en_q),
		.clear(feed_w),
		.sel(sel_q),
		.count_q(pre_count_w),
		.tap_q(tap_w)
	);

	// Avalon slave: one wait cycle, read data captured at request start
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			avs_rsp.waitrequest <= 1'b1;
			avs_rsp.readdata <= 32'h00000000;
		end
		else
		begin
			avs_rsp.waitrequest <= !(req_w && avs_rsp.waitrequest);
			if (avs_req.read && avs_rsp.waitrequest)
				avs_rsp.readdata <= rdata_w;
		end
	end

	// Control and reload registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sel_q <= RST_SEL;
			run_q <= RST_RUN;
			mode_q <= RST_MODE;
			reload_q <= RST_RELOAD;
		end
		else
		begin
			if (wr_ctrl_w)
			begin
				sel_q <= avs_req.writedata[CTRL_SEL_LSB +: 3];
				run_q <= avs_req.writedata[CTRL_RUN_BIT];
				mode_q <= avs_req.writedata[CTRL_MODE_BIT];
			end
			if (wr_reload_w)
				reload_q <= avs_req.writedata[CNT_W-1:0];
		end
	end

	// Timeout flag: expiry wins over a software clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			timeout_q <= 1'b0;
		else if (expire_w)
			timeout_q <= 1'b1;
		else if (wr_ctrl_w && !avs_req.writedata[CTRL_FLAG_BIT])
			timeout_q <= 1'b0;
	end

	// Main down-counter
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cnt_q <= RST_RELOAD;
		else
			cnt_q <= cnt_d;
	end

	// Stretch the system reset so the rest of the chip sees it clearly
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sys_reset_q <= 1'b0;
			rst_cnt_q <= 5'h00;
		end
		else if (expire_w && mode_q)
		begin
			sys_reset_q <= 1'b1;
			rst_cnt_q <= RST_PULSE_LAST;
		end
		else if (rst_cnt_q != 5'h00)
			rst_cnt_q <= rst_cnt_q - 5'h01;
		else
			sys_reset_q <= 1'b0;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Expiry in watchdog mode, then a held reset pulse
	sequence s_wd_expire;
		expire_w && mode_q;
	endsequence
	sequence s_reset_held;
		sys_reset_q [*8];
	endsequence

	a_reset_on_zero: assert property (s_wd_expire |=> s_reset_held)
		else $error("watchdog expiry did not raise a held system reset");
	a_timer_no_reset: assert property (!sys_reset_q && expire_w && !mode_q |=> !sys_reset_q)
		else $error("timer mode expiry raised system reset");
	a_timer_reload: assert property (expire_w && !feed_w |=>
		timeout_q && cnt_q == $past(reload_q))
		else $error("expiry did not set flag and reload counter");
	a_count_dec: assert property (dec_w && !feed_w && !expire_w |=>
		cnt_q == $past(cnt_q) - 8'h01)
		else $error("main counter did not decrement on tap");
	a_feed_load: assert property (feed_w |=> cnt_q == $past(reload_q) && pre_count_w == '0)
		else $error("feed did not reload counter and clear prescaler");
	a_only_feed: assert property (!feed_w && !expire_w |=> cnt_q <= $past(cnt_q))
		else $error("counter rose without feed or expiry");
	a_mc_period: assert property (mc_en_q |=> !mc_en_q ##11 mc_en_q)
		else $error("machine cycle enable not every twelve clocks");
	a_sel_write: assert property (wr_ctrl_w |=> sel_q == $past(avs_req.writedata[CTRL_SEL_LSB +: 3]))
		else $error("prescale select not written");
	a_no_dec_idle: assert property (!run_q && !feed_w |=> cnt_q == $past(cnt_q))
		else $error("stopped counter changed");

endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking testbench for the watchdog timer block
`timescale 1ns/10ps
`default_nettype none
module tb
	import wdt_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	wdt_avs_req_type avs_req = '0;
	wdt_avs_rsp_type avs_rsp;
	logic sys_reset_q;
	logic timeout_q;
	logic saw_rst = 1'b0;
	logic [3:0] be = 4'h1;
	int mismatches = 0;
	int n_compared = 0;
	int n;

	// Oscillator stand-in
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

	// Sticky record of any reset pulse; never cleared
	always @(posedge clk_sys)
		if (sys_reset_q === 1'b1)
			saw_rst <= 1'b1;

	wdt_watchdog dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.avs_req(avs_req),
		.avs_rsp(avs_rsp),
		.sys_reset_q(sys_reset_q),
		.timeout_q(timeout_q)
	);

	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
			mismatches++;
		end
	endtask

	task automatic check_rng(input logic [31:0] got, input int lo, input int hi, input string what);
		n_compared++;
		// Unknown bits must not slip through the range test
		if ($isunknown(got) || got < lo || got > hi)
		begin
			$display("ERROR %0t %s: %0d outside %0d..%0d", $time, what, got, lo, hi);
			mismatches++;
		end
	endtask

	// One Avalon-MM transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int i;
		avs_req.read <= ~wr;
		avs_req.write <= wr;
		avs_req.address <= a;
		avs_req.writedata <= {24'h0, d};
		avs_req.byteenable <= be;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk_sys);
			if (avs_rsp.waitrequest === 1'b0)
				break;
		end
		q = avs_rsp.readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		// Extra edge so the next request never lands in this time step
		@(posedge clk_sys);
		if (i == 50)
		begin
			$display("ERROR %0t bus wait timed out", $time);
			mismatches++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check_eq(q, exp, what);
	endtask

	// Control write: select, run, mode; flag bit written 0 clears it
	task automatic ctrl(input logic [2:0] s, input logic run, input logic mode);
		wr(OFS_CTRL, {s, 2'b00, run, 1'b0, mode});
	endtask

	task automatic wait_hi(input bit rs, input int lim, output int cyc);
		for (cyc = 1; cyc <= lim; cyc++)
		begin
			@(posedge clk_sys);
			if ((rs ? sys_reset_q : timeout_q) === 1'b1)
				return;
		end
		$display("ERROR %0t output never rose", $time);
		mismatches++;
		print_verdict();
	endtask

	task automatic t_reset();
		rdc(OFS_CTRL, 32'h0000_0000, "ctrl reset");
		rdc(OFS_RELOAD, 32'h0000_00FF, "reload reset");
		rdc(OFS_COUNT, 32'h0000_00FF, "counter reset");
		rdc(5'h14, 32'h0000_0000, "unmapped read");
		check_eq(32'(sys_reset_q), 32'h0, "no reset pulse");
	endtask

	// Every select code reads back; reserved bits and flag write-1 stay 0
	task automatic t_select();
		int s;
		for (s = 0; s < 8; s++)
		begin
			wr(OFS_CTRL, 8'(s << 5) | 8'h1B);
			rdc(OFS_CTRL, 32'(s << 5) | 32'h01, "select readback");
		end
		ctrl(3'h0, 1'b0, 1'b0);
	endtask

	task automatic t_reload();
		logic [31:0] q;
		wr(OFS_RELOAD, 8'h55);
		rdc(OFS_COUNT, 32'h0000_00FF, "reload write alone");
		wr(OFS_FEED, 8'h00);
		rdc(OFS_COUNT, 32'h0000_0055, "feed loads counter");
		bus(1'b0, OFS_PRESC, 8'h00, q);
		check_rng(q, 0, 1, "feed clears prescaler");
	endtask

	// Refused writes: control without byte lane 0, and the read-only counter
	task automatic t_refuse();
		be = 4'h0;
		wr(OFS_CTRL, 8'hE1);
		be = 4'h1;
		rdc(OFS_CTRL, 32'h0000_0000, "ctrl write without lane 0");
		wr(OFS_COUNT, 8'h12);
		rdc(OFS_COUNT, 32'h0000_0055, "counter is read only");
	endtask

	// Timer mode: one tap from reload 1 expires, period doubles per code
	task automatic t_timer();
		int s;
		int per;
		wr(OFS_RELOAD, 8'h01);
		for (s = 0; s < 4; s++)
		begin
			per = (64 * 12) << s;
			ctrl(3'(s), 1'b0, 1'b0);
			wr(OFS_FEED, 8'h00);
			ctrl(3'(s), 1'b1, 1'b0);
			wait_hi(1'b0, per + 100, n);
			check_rng(n, per - 40, per + 40, "tap period");
		end
		check_eq(32'(saw_rst), 32'h0, "timer mode no reset");
		ctrl(3'h0, 1'b0, 1'b0);
		rdc(OFS_CTRL, 32'h0000_0000, "flag cleared by write 0");
	endtask

	// Watchdog mode: fed in time it stays quiet, starved it resets
	task automatic t_wdog();
		ctrl(3'h0, 1'b0, 1'b1);
		wr(OFS_RELOAD, 8'h02);
		wr(OFS_FEED, 8'h00);
		ctrl(3'h0, 1'b1, 1'b1);
		repeat (4)
		begin
			repeat (1000) @(posedge clk_sys);
			wr(OFS_FEED, 8'h00);
		end
		check_eq(32'(saw_rst), 32'h0, "fed watchdog quiet");
		wait_hi(1'b1, 3000, n);
		check_rng(n, 1536 - 40, 1536 + 40, "starved interval");
		check_eq(32'(timeout_q), 32'h1, "flag on expiry");
		n = 1;
		repeat (40)
		begin
			@(posedge clk_sys);
			if (sys_reset_q !== 1'b1)
				break;
			n++;
		end
		check_eq(32'(n), 32'(RST_PULSE_CYC), "reset pulse width");
		ctrl(3'h0, 1'b0, 1'b0);
	endtask

	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_select();
		t_reload();
		t_refuse();
		t_timer();
		t_wdog();
		print_verdict();
	end
endmodule
`default_nettype wire
